/* File: mdc_pkg.sv */
package mdc_pkg;
  // sizes
  localparam int N_DMA         = 64;
  localparam int N_QCH         = 8;
  localparam int N_CH          = 72;
  localparam int N_SET         = 128;
  localparam int N_WORD        = 8;
  localparam int N_ENG         = 2;
  localparam int QUEUE_DEPTH   = 16;
  localparam int TR_FIFO_DEPTH = 4;
  localparam int MAX_INFLIGHT  = 4;
  localparam int CW            = 7;
  localparam int SW            = 7;
  localparam int QW            = 3;
  localparam int ADW           = 32;
  localparam int DW            = 64;
  localparam int HALF          = 16;
  localparam int FLW           = 3;
  // descriptor word indices
  localparam logic [2:0] W_OPT  = 3'h0;
  localparam logic [2:0] W_SRC  = 3'h1;
  localparam logic [2:0] W_CNT  = 3'h2;
  localparam logic [2:0] W_DST  = 3'h3;
  localparam logic [2:0] W_BIDX = 3'h4;
  localparam logic [2:0] W_LNK  = 3'h5;
  localparam logic [2:0] W_CIDX = 3'h6;
  localparam logic [2:0] W_CCNT = 3'h7;
  // option and link bit positions
  localparam int OPT_SCONST = 0;
  localparam int OPT_DCONST = 1;
  localparam int OPT_AB     = 2;
  localparam int OPT_QSEL   = 3;
  localparam int OPT_CHEN   = 4;
  localparam int OPT_ICHEN  = 5;
  localparam int OPT_CTGT   = 8;
  localparam int LNK_NONE   = 15;
  // constants
  localparam logic [15:0]    CNT_ONE    = 16'h0001;
  localparam logic [15:0]    CNT_ZERO   = 16'h0000;
  localparam logic [ADW-1:0] BEAT_BYTES = 32'h0000_0008;
  localparam logic [FLW-1:0] FL_ONE     = 3'h1;
  localparam logic [2:0]     QENT_RST   = 3'h7;
  typedef logic [N_WORD-1:0][31:0] mdc_desc_t;
  typedef struct packed {
    logic [SW-1:0] set;   logic [ADW-1:0] src;  logic [ADW-1:0] dst;
    logic [15:0]   acnt;  logic [15:0]    rows; logic [15:0]    sidx;
    logic [15:0]   didx;  logic sconst; logic dconst; logic chain; logic last;
    logic [5:0]    ctgt;
  } mdc_tr_t;
  typedef struct packed { logic [CW-1:0] chan; } mdc_qent_t;
  typedef struct packed {
    logic req; logic [SW-1:0] set; logic [2:0] entry; logic [31:0] data;
  } mdc_dwr_t;
  typedef struct packed {
    logic we; logic [QW-1:0] idx; logic [SW-1:0] set; logic [2:0] entry;
  } mdc_qmap_t;
  typedef struct packed { logic null_trig; logic q_ovf; logic [CW-1:0] chan; } mdc_err_t;
  typedef enum logic [2:0] {E_IDLE = 3'b001, E_WAIT = 3'b010, E_WRITE = 3'b100} mdc_est_t;
endpackage

/* File: mdc_dma_controller.sv */
`timescale 1ns/1ps

// generic valid/ready fifo
module mdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW-1:0]    wp_r;         // write pointer
  logic [AW-1:0]    rp_r;         // read pointer
  logic [AW:0]      cnt_r;        // fill level
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;
  assign in_ready  = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data  = mem[rp_r];
  // pointers and level
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      if (push & ~pop) cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push) cnt_r <= cnt_r - 1'b1;
    end
  end
  // data array, no reset needed
  always_ff @(posedge clk_sys) begin
    if (push) mem[wp_r] <= in_data;
  end
endmodule

// channel scheduler plus two transfer engines
module mdc_dma_controller
  import mdc_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  // peripheral event pins
  input  wire logic [N_DMA-1:0]         evt_pin,
  // software programming
  input  wire logic [N_DMA-1:0]         evt_set,
  input  mdc_dwr_t                      desc_wr,
  input  mdc_qmap_t                     qmap_wr,
  input  wire logic                     q1_first,
  // engine read ports
  output logic [N_ENG-1:0]              rd_req,
  output logic [N_ENG-1:0][ADW-1:0]     rd_addr,
  input  wire logic [N_ENG-1:0]         rd_valid,
  input  wire logic [N_ENG-1:0][DW-1:0] rd_data,
  // engine write ports
  output logic [N_ENG-1:0]              wr_req,
  output logic [N_ENG-1:0][ADW-1:0]     wr_addr,
  output logic [N_ENG-1:0][DW-1:0]      wr_data,
  input  wire logic [N_ENG-1:0]         wr_ack,
  // completion and error report
  output logic                          done_irq,
  output logic [SW-1:0]                 done_set,
  output logic                          err_irq,
  output mdc_err_t                      err_status
);
  // lowest pending channel, msb is valid
  function automatic logic [CW:0] first_one(input logic [N_CH-1:0] v);
    first_one = '0;
    for (int i = N_CH - 1; i >= 0; i--) begin
      if (v[i]) first_one = {1'b1, CW'(i)};
    end
  endfunction
  // channel to one-hot pending bit
  function automatic logic [N_CH-1:0] ch_onehot(input logic [CW-1:0] c);
    ch_onehot    = '0;
    ch_onehot[c] = 1'b1;
  endfunction
  // sign extend an index
  function automatic logic [ADW-1:0] sext(input logic [15:0] v);
    sext = {{HALF{v[15]}}, v};
  endfunction

  logic [N_DMA-1:0]  s1_r, s2_r, s3_r;     // pin synchroniser
  logic [N_DMA-1:0]  lvl_r;                // filtered pin level
  logic [N_CH-1:0]   pend_r;               // pending triggers
  logic [N_CH-1:0]   pend_set;             // new triggers
  logic [N_CH-1:0]   pend_clr;             // queued triggers
  logic [N_QCH-1:0]  qtrig;                // quick triggers
  logic [SW-1:0]     qset_r [N_QCH];       // quick channel set map
  logic [2:0]        qent_r [N_QCH];       // quick trigger entry
  mdc_desc_t         ram [N_SET];          // descriptor ram
  logic [N_ENG-1:0]  q_in_ready, q_in_valid, q_out_valid, q_pop;
  mdc_qent_t         q_head [N_ENG];
  logic [N_ENG-1:0]  tr_ready, tr_push, eng_done;
  mdc_tr_t           eng_cur [N_ENG];
  mdc_tr_t           tr;
  mdc_desc_t         d_upd;
  mdc_err_t          err_r;
  logic              err_irq_r, done_irq_r;
  logic [SW-1:0]     done_set_r;

  // set that serves a channel
  function automatic logic [SW-1:0] chan_set(input logic [CW-1:0] c);
    chan_set = c[CW-1] ? qset_r[c[QW-1:0]] : c[SW-1:0];
  endfunction

  // three-stage pin synchroniser and agreement filter
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      lvl_r <= '0;
    end else begin
      s1_r  <= evt_pin;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
    end
  end
  wire [N_DMA-1:0] evt_edge = s2_r & s3_r & ~lvl_r;

  // quick trigger on write of mapped entry
  genvar gq;
  generate
    for (gq = 0; gq < N_QCH; gq++) begin : g_qch
      assign qtrig[gq] = desc_wr.req & (desc_wr.set == qset_r[gq])
                       & (desc_wr.entry == qent_r[gq]);
      // map register
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          qset_r[gq] <= SW'(gq);
          qent_r[gq] <= QENT_RST;
        end else if (qmap_wr.we && qmap_wr.idx == QW'(gq)) begin
          qset_r[gq] <= qmap_wr.set;
          qent_r[gq] <= qmap_wr.entry;
        end
      end
    end
  endgenerate

  // gather triggers: events, manual, quick, chains
  always_comb begin
    pend_set = {qtrig, evt_edge | evt_set};
    for (int e = 0; e < N_ENG; e++) begin
      if (eng_done[e] && eng_cur[e].chain)
        pend_set = pend_set | ch_onehot({1'b0, eng_cur[e].ctgt});
    end
  end

  // enqueue: lowest pending channel into its queue
  wire [CW:0]    pick    = first_one(pend_r);
  wire           enq_v   = pick[CW];
  wire [CW-1:0]  enq_ch  = pick[CW-1:0];
  wire [SW-1:0]  enq_set = chan_set(enq_ch);
  wire           enq_q   = ram[enq_set][W_OPT][OPT_QSEL];
  wire           enq_ovf = enq_v & ~q_in_ready[enq_q];
  assign pend_clr   = enq_v ? ch_onehot(enq_ch) : '0;
  assign q_in_valid = {enq_v & enq_q, enq_v & ~enq_q};

  // pending flags, a new trigger wins over the clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) pend_r <= '0;
    else pend_r <= (pend_r & ~pend_clr) | pend_set;
  end

  // dequeue: priority pick between queue heads
  wire [N_ENG-1:0] q_ok   = q_out_valid & tr_ready;
  wire             sel    = q_ok[1] & (q1_first | ~q_ok[0]);
  wire             sub_v  = (|q_ok) & ~desc_wr.req;
  wire [SW-1:0]    sub_set = chan_set(q_head[sel].chan);
  mdc_desc_t       d;
  assign d = ram[sub_set];
  // descriptor field decode
  wire [15:0] acnt    = d[W_CNT][15:0];
  wire [15:0] bcnt    = d[W_CNT][31:16];
  wire [15:0] ccnt    = d[W_CCNT][15:0];
  wire        is_ab   = d[W_OPT][OPT_AB];
  wire        null_set = (acnt == CNT_ZERO) & (bcnt == CNT_ZERO)
                       & (ccnt == CNT_ZERO);
  wire        dummy   = ((acnt == CNT_ZERO) | (bcnt == CNT_ZERO)
                       | (ccnt == CNT_ZERO)) & ~null_set;
  wire        a_last  = bcnt == CNT_ONE;
  wire        use_c   = is_ab | a_last;
  wire        last    = (ccnt == CNT_ONE) & use_c;
  wire        link_ok = ~d[W_LNK][LNK_NONE];
  wire [SW-1:0] link  = d[W_LNK][SW-1:0];
  wire [ADW-1:0] sstep = sext(use_c ? d[W_CIDX][15:0] : d[W_BIDX][15:0]);
  wire [ADW-1:0] dstep = sext(use_c ? d[W_CIDX][31:16] : d[W_BIDX][31:16]);

  // second or third dimension advance written back after each request
  always_comb begin
    d_upd                 = d;
    d_upd[W_SRC]          = d[W_SRC] + sstep;
    d_upd[W_DST]          = d[W_DST] + dstep;
    d_upd[W_CNT][31:16]   = is_ab ? bcnt : (a_last ? d[W_LNK][31:16] : bcnt - CNT_ONE);
    d_upd[W_CCNT][15:0]   = use_c ? ccnt - CNT_ONE : ccnt;
  end
  // final or dummy set reloads from its link set
  wire        reload  = link_ok & (last | dummy);
  wire        wb_en   = sub_v & ~null_set & (~dummy | link_ok);
  wire        tr_go   = sub_v & ~null_set & ~dummy;
  wire mdc_desc_t wb_data = reload ? ram[link] : d_upd;
  assign q_pop   = {sub_v & sel, sub_v & ~sel};
  assign tr_push = {tr_go & sel, tr_go & ~sel};

  // transfer request built from the set
  always_comb begin
    tr        = '0;
    tr.set    = sub_set;
    tr.src    = d[W_SRC];
    tr.dst    = d[W_DST];
    tr.acnt   = acnt;
    tr.rows   = is_ab ? bcnt : CNT_ONE;
    tr.sidx   = d[W_BIDX][15:0];
    tr.didx   = d[W_BIDX][31:16];
    tr.sconst = d[W_OPT][OPT_SCONST];
    tr.dconst = d[W_OPT][OPT_DCONST];
    tr.chain  = d[W_OPT][OPT_CHEN] & (last | d[W_OPT][OPT_ICHEN]);
    tr.last   = last;
    tr.ctgt   = d[W_OPT][OPT_CTGT +: 6];
  end

  // descriptor ram: software word writes, set writeback
  always_ff @(posedge clk_sys) begin
    if (desc_wr.req) ram[desc_wr.set][desc_wr.entry] <= desc_wr.data;
    else if (wb_en) ram[sub_set] <= wb_data;
  end

  // completion and error recording
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      err_r      <= '0;
      err_irq_r  <= 1'b0;
      done_irq_r <= 1'b0;
      done_set_r <= '0;
    end else begin
      err_irq_r <= (sub_v & null_set) | enq_ovf;
      if (sub_v & null_set) begin
        err_r.null_trig <= 1'b1;
        err_r.chan      <= q_head[sel].chan;
      end
      if (enq_ovf) begin
        err_r.q_ovf <= 1'b1;
        err_r.chan  <= enq_ch;
      end
      done_irq_r <= 1'b0;
      if (eng_done[0] & eng_cur[0].last) begin
        done_irq_r <= 1'b1;
        done_set_r <= eng_cur[0].set;
      end else if (eng_done[1] & eng_cur[1].last) begin
        done_irq_r <= 1'b1;
        done_set_r <= eng_cur[1].set;
      end
    end
  end
  assign err_irq    = err_irq_r;
  assign err_status = err_r;
  assign done_irq   = done_irq_r;
  assign done_set   = done_set_r;

  // two event queues and two transfer engines
  genvar g;
  generate
    for (g = 0; g < N_ENG; g++) begin : g_eng
      mdc_tr_t          tq_data, cur_r;
      logic             tq_valid, tq_ready, pop_tr;
      logic [FLW-1:0]   fl_r;
      mdc_est_t         st_r;
      logic [ADW-1:0]   sa_r, da_r, srow_r, drow_r;
      logic [15:0]      beat_r, row_r;
      logic             rdq_r, wrq_r, done_r;
      logic [ADW-1:0]   rda_r, wra_r;
      logic [DW-1:0]    wrd_r;
      // event queue of 16 entries
      mdc_fifo #(.WIDTH($bits(mdc_qent_t)), .DEPTH(QUEUE_DEPTH)) u_evq (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .in_valid  (q_in_valid[g]),
        .in_ready  (q_in_ready[g]),
        .in_data   (enq_ch),
        .out_valid (q_out_valid[g]),
        .out_ready (q_pop[g]),
        .out_data  (q_head[g])
      );
      // request buffer in front of the engine
      mdc_fifo #(.WIDTH($bits(mdc_tr_t)), .DEPTH(TR_FIFO_DEPTH)) u_trq (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .in_valid  (tr_push[g]),
        .in_ready  (tq_ready),
        .in_data   (tr),
        .out_valid (tq_valid),
        .out_ready (pop_tr),
        .out_data  (tq_data)
      );
      assign tr_ready[g] = tq_ready & (fl_r < FLW'(MAX_INFLIGHT));
      assign pop_tr      = tq_valid & (st_r == E_IDLE);
      // in-flight count: accepted but not yet done
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) fl_r <= '0;
        else if (tr_push[g] & ~done_r) fl_r <= fl_r + FL_ONE;
        else if (done_r & ~tr_push[g]) fl_r <= fl_r - FL_ONE;
      end
      // next addresses within a row and across rows
      wire           beat_end = (beat_r + CNT_ONE) == cur_r.acnt;
      wire           row_end  = (row_r + CNT_ONE) == cur_r.rows;
      wire [ADW-1:0] srow_n   = srow_r + sext(cur_r.sidx);
      wire [ADW-1:0] drow_n   = drow_r + sext(cur_r.didx);
      wire [ADW-1:0] sa_n     = beat_end ? srow_n
                              : (cur_r.sconst ? sa_r : sa_r + BEAT_BYTES);
      wire [ADW-1:0] da_n     = beat_end ? drow_n
                              : (cur_r.dconst ? da_r : da_r + BEAT_BYTES);
      // engine state machine: read beat, then write it
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          st_r <= E_IDLE;
          {cur_r, sa_r, da_r, srow_r, drow_r, beat_r, row_r} <= '0;
          {rdq_r, wrq_r, done_r, rda_r, wra_r, wrd_r} <= '0;
        end else begin
          rdq_r  <= 1'b0;
          wrq_r  <= 1'b0;
          done_r <= 1'b0;
          unique case (st_r)
            E_IDLE: if (tq_valid) begin
              cur_r  <= tq_data;
              {sa_r, srow_r, da_r, drow_r} <= {tq_data.src, tq_data.src, tq_data.dst, tq_data.dst};
              {beat_r, row_r} <= '0;
              rdq_r  <= 1'b1;
              rda_r  <= tq_data.src;
              st_r   <= E_WAIT;
            end
            E_WAIT: if (rd_valid[g]) begin
              wrq_r <= 1'b1;
              wra_r <= da_r;
              wrd_r <= rd_data[g];
              st_r  <= E_WRITE;
            end
            E_WRITE: if (wr_ack[g]) begin
              if (beat_end & row_end) begin
                done_r <= 1'b1;
                st_r   <= E_IDLE;
              end else begin
                {sa_r, da_r} <= {sa_n, da_n};
                rdq_r <= 1'b1;
                rda_r <= sa_n;
                st_r  <= E_WAIT;
                if (beat_end) begin
                  {srow_r, drow_r} <= {srow_n, drow_n};
                  beat_r <= '0;
                  row_r  <= row_r + CNT_ONE;
                end else beat_r <= beat_r + CNT_ONE;
              end
            end
          endcase
        end
      end
      assign rd_req[g]   = rdq_r;
      assign rd_addr[g]  = rda_r;
      assign wr_req[g]   = wrq_r;
      assign wr_addr[g]  = wra_r;
      assign wr_data[g]  = wrd_r;
      assign eng_done[g] = done_r;
      assign eng_cur[g]  = cur_r;
      // engine checks
      AST_INFLIGHT: assert property (@(posedge clk_sys) disable iff (!nrst)
        fl_r <= FLW'(MAX_INFLIGHT)) else $error("too many requests in flight");
      AST_RD_TO_WR: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st_r == E_WAIT && rd_valid[g]) |=> wr_req[g] && wr_data[g] == $past(rd_data[g])
        && wr_addr[g] == da_r) else $error("read beat not written to destination");
    end
  endgenerate

  // scheduler checks
  AST_A_ONE_ROW: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tr_go && !is_ab) |-> tr.rows == CNT_ONE) else $error("A-sync request not one row");
  AST_AB_ROWS: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tr_go && is_ab) |-> tr.rows == bcnt) else $error("AB-sync rows not B count");
  AST_DUMMY: assert property (@(posedge clk_sys) disable iff (!nrst)
    (sub_v && dummy) |-> !tr_go && !null_set) else $error("dummy set mishandled");
  AST_NULL_ERR: assert property (@(posedge clk_sys) disable iff (!nrst)
    (sub_v && null_set) |=> err_irq && err_status.null_trig) else $error("null set not flagged");
  AST_MANUAL: assert property (@(posedge clk_sys) disable iff (!nrst)
    (evt_set != '0) |=> (pend_r[N_DMA-1:0] & $past(evt_set)) == $past(evt_set))
    else $error("manual trigger lost");
  AST_QTRIG: assert property (@(posedge clk_sys) disable iff (!nrst)
    (qtrig != '0) |=> (pend_r[N_CH-1:N_DMA] & $past(qtrig)) == $past(qtrig))
    else $error("quick trigger lost");
  AST_OVF: assert property (@(posedge clk_sys) disable iff (!nrst)
    enq_ovf |=> err_irq && err_status.q_ovf && err_status.chan == $past(enq_ch))
    else $error("queue overflow not recorded");
endmodule

/* File: mdc_mem_slave.sv */
`timescale 1ns/1ps
// behavioural memory slave answering the read and write ports of both engines
module mdc_mem_slave
  import mdc_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  // reply pace, high stretches every answer
  input  wire logic                      slow,
  // read ports
  input  wire logic [N_ENG-1:0]          rd_req,
  input  wire logic [N_ENG-1:0][ADW-1:0] rd_addr,
  output logic [N_ENG-1:0]               rd_valid,
  output logic [N_ENG-1:0][DW-1:0]       rd_data,
  // write ports
  input  wire logic [N_ENG-1:0]          wr_req,
  output logic [N_ENG-1:0]               wr_ack
);
  int          rcnt [N_ENG];  // cycles left to the read reply
  int          wcnt [N_ENG];  // cycles left to the write ack
  logic [31:0] ra   [N_ENG];  // address latched at the read command
  // one reply per command, never in the command's own cycle
  always @(posedge clk_sys or negedge nrst) begin
    for (int e = 0; e < N_ENG; e++) begin
      if (!nrst) begin
        rcnt[e] = 0;
        wcnt[e] = 0;
        rd_valid[e] <= 1'b0;
        wr_ack[e] <= 1'b0;
        rd_data[e] <= '0;
      end else begin
        rd_valid[e] <= 1'b0;
        wr_ack[e] <= 1'b0;
        rd_data[e] <= ~rd_data[e];  // idle data keeps flipping
        if (rd_req[e]) begin
          rcnt[e] = slow ? 4 : 1;
          ra[e] = rd_addr[e];
        end else if (rcnt[e] > 0) begin
          rcnt[e] = rcnt[e] - 1;
          if (rcnt[e] == 0) begin
            rd_valid[e] <= 1'b1;
            rd_data[e] <= {ra[e], ~ra[e]};  // data names its source
          end
        end
        if (wr_req[e]) begin
          wcnt[e] = slow ? 3 : 1;
        end else if (wcnt[e] > 0) begin
          wcnt[e] = wcnt[e] - 1;
          if (wcnt[e] == 0) begin
            wr_ack[e] <= 1'b1;
          end
        end
      end
    end
  end
endmodule

/* File: mdc_dma_controller_test.sv */
`timescale 1ns/1ps
// bench: reference queues built from transfer geometry
module multichannel_dma_controller_test
  import mdc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic nrst;
  logic [N_DMA-1:0] evt_pin;
  logic [N_DMA-1:0] evt_set;
  mdc_dwr_t desc_wr;
  mdc_qmap_t qmap_wr;
  logic q1_first;
  logic slow;
  logic [N_ENG-1:0] rd_req, rd_valid, wr_req, wr_ack;
  logic [N_ENG-1:0][ADW-1:0] rd_addr, wr_addr;
  logic [N_ENG-1:0][DW-1:0] rd_data, wr_data;
  logic done_irq, err_irq;
  logic [SW-1:0] done_set;
  mdc_err_t err_status;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_err = 0;
  logic [95:0] expq [N_ENG][$];  // expected beats {dst, data}
  logic [95:0] doneq [$];        // expected finished sets
  logic [31:0] sa, da;

  always #20 clk_sys = ~clk_sys;

  mdc_dma_controller DUT (.clk_sys, .nrst, .evt_pin, .evt_set, .desc_wr, .qmap_wr, .q1_first,
    .rd_req, .rd_addr, .rd_valid, .rd_data, .wr_req, .wr_addr, .wr_data, .wr_ack,
    .done_irq, .done_set, .err_irq, .err_status);
  mdc_mem_slave slave (.clk_sys, .nrst, .slow, .rd_req, .rd_addr, .rd_valid, .rd_data,
    .wr_req, .wr_ack);

  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  // every write beat and completion against the reference
  always @(posedge clk_sys) begin
    for (int e = 0; e < N_ENG; e++) begin
      if (wr_req[e] === 1'b1) begin
        chk({wr_addr[e], wr_data[e]}, expq[e].size() ? expq[e].pop_front() : '1, "beat");
      end
    end
    if (done_irq === 1'b1) begin
      chk(96'(done_set), doneq.size() ? doneq.pop_front() : '1, "done");
    end
    if (err_irq === 1'b1) begin
      n_err++;
    end
  end

  // reference beats: rows of acnt beats, sources step ss, destinations ds
  task automatic rows(input int e, input logic [31:0] s, d, input int acnt, nrow, idx, ss, ds);
    logic [31:0] a;
    for (int r = 0; r < nrow; r++) begin
      for (int b = 0; b < acnt; b++) begin
        a = s + 32'(r * idx + b * ss);
        expq[e].push_back({d + 32'(r * idx + b * ds), a, ~a});
      end
    end
  endtask

  task automatic dw(input logic [6:0] s, input logic [2:0] e, input logic [31:0] d);
    desc_wr <= '{req: 1'b1, set: s, entry: e, data: d};
    @(posedge clk_sys);
    #1;
  endtask

  task automatic prog(input logic [6:0] s, input logic [31:0] opt, src, cnt, dst, idx, lnk, cc);
    logic [31:0] w [8] = '{opt, src, cnt, dst, idx, lnk, 32'h0, cc};
    for (int i = 0; i < 8; i++) begin
      dw(s, 3'(i), w[i]);
    end
    desc_wr <= '0;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic trig(input int ch);
    evt_set[ch] <= 1'b1;
    @(posedge clk_sys);
    #1;
    evt_set <= '0;
  endtask

  task automatic settle();
    for (int i = 0; i < 800 && expq[0].size() + expq[1].size() + doneq.size() > 0; i++) begin
      @(posedge clk_sys);
    end
    repeat (20) @(posedge clk_sys);
    #1;
    chk(96'(expq[0].size() + expq[1].size() + doneq.size()), 96'h0, "left over");
  endtask

  initial begin
    void'($urandom(32'h42e1));
    // idle levels start zero, queue priority and slave pace start random
    nrst     = 1'b0;
    evt_pin  = '0;
    evt_set  = '0;
    desc_wr  = '0;
    qmap_wr  = '0;
    q1_first = 1'($urandom);
    slow     = 1'($urandom);
    repeat (12) @(posedge clk_sys);
    #1;
    nrst <= 1'b1;
    @(posedge clk_sys);
    #1;
    sa = $urandom & 32'h7fff_f000;
    da = $urandom & 32'h7fff_f000;
    // two rows, one per trigger, completion on the second
    prog(7'd10, 32'h0, sa, 32'h0002_0002, da, 32'h0040_0040, 32'h0002_8000, 32'd1);
    rows(0, sa, da, 2, 1, 64, 8, 8);
    trig(10);
    settle();
    rows(0, sa + 64, da + 64, 2, 1, 64, 8, 8);
    doneq.push_back(96'd10);
    trig(10);
    settle();
    // three rows from one trigger, slow slave
    slow <= 1'b1;
    prog(7'd11, 32'h4, sa, 32'h0003_0001, da, 32'h0020_0020, 32'h8000, 32'd1);
    rows(0, sa, da, 1, 3, 32, 8, 8);
    doneq.push_back(96'd11);
    trig(11);
    settle();
    // constant addresses on both sides
    slow <= 1'($urandom);
    prog(7'd12, 32'h3, sa, 32'h0001_0003, da, 32'h0, 32'h8000, 32'd1);
    rows(0, sa, da, 3, 1, 0, 0, 0);
    doneq.push_back(96'd12);
    trig(12);
    settle();
    // dummy set: nothing moves, no error
    prog(7'd13, 32'h0, sa, 32'h0000_0001, da, 32'h0, 32'h8000, 32'd1);
    trig(13);
    settle();
    chk(96'(err_status), 96'h0, "dummy flagged");
    // null set: error with the channel
    prog(7'd14, 32'h0, sa, 32'h0, da, 32'h0, 32'h8000, 32'd0);
    trig(14);
    settle();
    chk(96'(err_status), 96'h10e, "null status");
    chk(96'(n_err), 96'd1, "error pulses");
    // chain from 15 to 16
    prog(7'd16, 32'h0, sa + 256, 32'h0001_0001, da + 256, 32'h0, 32'h8000, 32'd1);
    prog(7'd15, 32'h1010, sa, 32'h0001_0001, da, 32'h0, 32'h8000, 32'd1);
    rows(0, sa, da, 1, 1, 0, 8, 8);
    rows(0, sa + 256, da + 256, 1, 1, 0, 8, 8);
    doneq.push_back(96'd15);
    doneq.push_back(96'd16);
    trig(15);
    settle();
    // quick channel 2 remapped to set 100, fired by its link word
    qmap_wr <= '{we: 1'b1, idx: 3'd2, set: 7'd100, entry: 3'd5};
    @(posedge clk_sys);
    #1;
    qmap_wr <= '0;
    rows(0, sa, da, 1, 1, 0, 8, 8);
    doneq.push_back(96'd100);
    prog(7'd100, 32'h0, sa, 32'h0001_0001, da, 32'h0, 32'h8000, 32'd1);
    settle();
    // pin event on the second queue and engine
    q1_first <= 1'b1;
    prog(7'd17, 32'h8, da, 32'h0001_0002, sa, 32'h0, 32'h8000, 32'd1);
    rows(1, da, sa, 2, 1, 0, 8, 8);
    doneq.push_back(96'd17);
    evt_pin[17] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    evt_pin[17] <= 1'b0;
    settle();
    // link reload: second trigger moves the link set's data
    prog(7'd19, 32'h0, sa + 512, 32'h0001_0001, da + 512, 32'h0, 32'h8000, 32'd1);
    prog(7'd18, 32'h0, sa, 32'h0001_0001, da, 32'h0, 32'h13, 32'd1);
    rows(0, sa, da, 1, 1, 0, 8, 8);
    doneq.push_back(96'd18);
    trig(18);
    settle();
    rows(0, sa + 512, da + 512, 1, 1, 0, 8, 8);
    doneq.push_back(96'd18);
    trig(18);
    settle();
    finish_test();
  end
endmodule
